// [core/plbc_ctrl.sv]
// Overview of operation
// [RULE1] Reference clock is crystal clock divided by one to eight.
// [RULE2] Feedback divider makes the VCO run at one to sixty-four times reference.
// [RULE3] A selected loop keeps running through WAIT mode.
// [RULE4] Loop is suspended during STOP mode.
// [RULE5] After STOP and stabilization, loop resumes only with automatic bandwidth.
// [RULE6] Lock detector compares divided feedback against final reference clock.
// [RULE7] Acquisition mode shows as filter-track-select bit cleared.
// [RULE8] Filter tracks whenever filter-track-select bit is set.
// [RULE9] Automatic mode switches filter between acquisition and tracking itself.
// [RULE10] In automatic mode track bit is read-only, set and cleared by hardware.
// [RULE11] Lock bit is read-only with lock and unlock tolerances.
// [RULE12] Lock toggle requests interrupt when lock interrupt enabled.
// [RULE13] Set lock bit means VCO clock is safe as base clock.
// [RULE14] Manual mode keeps lock detection and lock interrupt active.
// [RULE15] Manual mode track bit is writable and selects filter mode directly.
// [RULE16] Software clears track bit before switching loop on manually.
// [RULE17] Software waits acquisition time before requesting tracking manually.
// [RULE18] Lock interrupt stays pending until software acknowledges it.
`timescale 1ns/1ps
`include "plbc_regs.svh"

module plbc_ctrl
    import plbc_pkg::*;
#(
    parameter int WIN = `PLBC_WIN,
    parameter int STAB_CYC = `PLBC_STAB_CYC
)
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic [`PLBC_ADDR_W-1:0] i_addr,
    input wire logic [`PLBC_DATA_W-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_xtal_clk,
    input wire logic i_vco_output_clock,
    input wire logic i_wait_mode,
    input wire logic i_stop_mode,
    output logic [`PLBC_DATA_W-1:0] o_rd_data,
    output logic o_final_reference_clock,
    output logic o_feedback_divided_clock,
    output logic o_loop_run,
    output logic o_filter_track,
    output logic o_lock,
    output logic o_irq
);

    localparam logic [`PLBC_STAB_W-1:0] STAB_LOAD =
        `PLBC_STAB_W'(STAB_CYC);

    plbc_state_t s;
    plbc_state_t next_s;
    logic xtal_rise;
    logic vco_rise;
    logic wr_ctrl;
    logic wr_status;
    logic det_valid;
    logic [`PLBC_ERR_W-1:0] det_err;

    // ------------------------------------------------------------
    // Lock detector
    // ------------------------------------------------------------
    plbc_lock_det #(
        .WIN(WIN)
    ) u_det (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_enable(s.loop_run),
        .i_ref_tick(s.ref_pulse),
        .i_fb_tick(s.fb_pulse),
        .o_valid(det_valid),
        .o_err(det_err)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        xtal_rise = i_xtal_clk && !s.prev_xtal;
        vco_rise = i_vco_output_clock && !s.prev_vco;
        wr_ctrl = i_wr && i_addr == `PLBC_OFS_CTRL;
        wr_status = i_wr && i_addr == `PLBC_OFS_STATUS;
        next_s.prev_xtal = i_xtal_clk;
        next_s.prev_vco = i_vco_output_clock;
        next_s.stop_q = i_stop_mode;
        next_s.ref_pulse = 1'b0;
        next_s.fb_pulse = 1'b0;

        // Reference divider, divide by ref_div + 1
        if (xtal_rise)
        begin
            if (s.ref_cnt >= s.ref_div)
            begin
                next_s.ref_cnt = '0;
                next_s.ref_pulse = 1'b1; // [RULE1]
            end
            else
            begin
                next_s.ref_cnt = s.ref_cnt + `PLBC_DIV_W'(1);
            end
        end

        // Feedback divider, divide by mult + 1
        if (!s.loop_run)
        begin
            next_s.fb_cnt = '0;
        end
        else if (vco_rise)
        begin
            if (s.fb_cnt >= s.mult)
            begin
                next_s.fb_cnt = '0;
                next_s.fb_pulse = 1'b1; // [RULE2]
            end
            else
            begin
                next_s.fb_cnt = s.fb_cnt + `PLBC_MUL_W'(1);
            end
        end

        // Register writes
        if (wr_ctrl)
        begin
            next_s.auto_bw = i_wr_data[`PLBC_CTRL_AUTO];
            next_s.pwr = i_wr_data[`PLBC_CTRL_PWR];
            next_s.lie = i_wr_data[`PLBC_CTRL_LIE];
            if (!s.auto_bw)
            begin
                next_s.fts = i_wr_data[`PLBC_CTRL_FTS]; // [RULE15]
            end
        end
        if (i_wr && i_addr == `PLBC_OFS_REFDIV)
        begin
            next_s.ref_div = i_wr_data[`PLBC_DIV_W-1:0];
        end
        if (i_wr && i_addr == `PLBC_OFS_MULT)
        begin
            next_s.mult = i_wr_data[`PLBC_MUL_W-1:0];
        end

        // Leaving STOP in manual mode leaves the loop off
        if (s.stop_q && !i_stop_mode && !s.auto_bw)
        begin
            next_s.pwr = 1'b0; // [RULE5]
        end

        // Loop phase; WAIT has no say here
        case (s.lp)
            LP_OFF:
            begin
                if (s.pwr && !i_stop_mode)
                begin
                    next_s.lp = LP_STAB;
                    next_s.stab_cnt = STAB_LOAD;
                end
            end
            LP_STAB:
            begin
                if (!s.pwr || i_stop_mode)
                begin
                    next_s.lp = LP_OFF; // [RULE4]
                end
                else if (s.stab_cnt == '0)
                begin
                    next_s.lp = LP_RUN; // [RULE5]
                end
                else
                begin
                    next_s.stab_cnt = s.stab_cnt - `PLBC_STAB_W'(1);
                end
            end
            LP_RUN:
            begin
                if (!s.pwr || i_stop_mode)
                begin
                    next_s.lp = LP_OFF; // [RULE4]
                end
            end
            default:
            begin
                next_s.lp = LP_OFF;
            end
        endcase
        next_s.loop_run = next_s.lp == LP_RUN; // [RULE3]

        // Lock indicator with hysteresis, in either mode
        if (!s.loop_run)
        begin
            next_s.lock = 1'b0;
        end
        else if (det_valid)
        begin
            if (det_err <= `PLBC_TOL_LOCK)
            begin
                next_s.lock = 1'b1; // [RULE11] [RULE14]
            end
            else if (det_err > `PLBC_TOL_UNL)
            begin
                next_s.lock = 1'b0; // [RULE11]
            end
        end

        // Automatic bandwidth control
        if (s.auto_bw)
        begin
            if (!s.loop_run)
            begin
                next_s.fts = 1'b0; // [RULE7]
            end
            else if (det_valid)
            begin
                if (det_err <= `PLBC_TOL_TRK)
                begin
                    next_s.fts = 1'b1; // [RULE9] [RULE10]
                end
                else if (det_err > `PLBC_TOL_UNT)
                begin
                    next_s.fts = 1'b0; // [RULE9] [RULE10]
                end
            end
        end

        // Lock change flag: a new change beats the acknowledge
        if (next_s.lock != s.lock)
        begin
            next_s.lock_flag = 1'b1; // [RULE12]
        end
        else if (wr_status && i_wr_data[`PLBC_ST_FLAG])
        begin
            next_s.lock_flag = 1'b0; // [RULE18]
        end
        next_s.irq = next_s.lock_flag && next_s.lie; // [RULE12]
        next_s.rd_data = '0;
        if (i_rd)
        begin
            case (i_addr)
                `PLBC_OFS_CTRL:
                begin
                    next_s.rd_data[`PLBC_CTRL_AUTO] = s.auto_bw;
                    next_s.rd_data[`PLBC_CTRL_PWR] = s.pwr;
                    next_s.rd_data[`PLBC_CTRL_LIE] = s.lie;
                    next_s.rd_data[`PLBC_CTRL_FTS] = s.fts; // [RULE7]
                end
                `PLBC_OFS_REFDIV:
                begin
                    next_s.rd_data[`PLBC_DIV_W-1:0] = s.ref_div;
                end
                `PLBC_OFS_MULT:
                begin
                    next_s.rd_data[`PLBC_MUL_W-1:0] = s.mult;
                end
                `PLBC_OFS_STATUS:
                begin
                    next_s.rd_data[`PLBC_ST_LOCK] = s.lock; // [RULE13]
                    next_s.rd_data[`PLBC_ST_FLAG] = s.lock_flag;
                    next_s.rd_data[`PLBC_ST_RUN] = s.loop_run;
                    next_s.rd_data[`PLBC_ST_TRK] = s.fts;
                end
                default:
                begin
                    next_s.rd_data = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            s <= '0;
            s.auto_bw <= `PLBC_RST_AUTO;
            s.ref_div <= `PLBC_RST_REFDIV;
            s.mult <= `PLBC_RST_MULT;
            s.lp <= LP_OFF;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign o_rd_data = s.rd_data;
    assign o_final_reference_clock = s.ref_pulse;
    assign o_feedback_divided_clock = s.fb_pulse;
    assign o_loop_run = s.loop_run;
    assign o_filter_track = s.fts; // [RULE8]
    assign o_lock = s.lock;
    assign o_irq = s.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_lock_off_loop: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn) !s.loop_run |=> !o_lock) // [RULE11]
        else $error("lock kept while loop not running");

    a_lock_set_win: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        s.loop_run && det_valid && det_err <= `PLBC_TOL_LOCK
        |=> o_lock) // [RULE6]
        else $error("lock not set inside lock tolerance");

    a_lock_drop_win: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        s.loop_run && det_valid && det_err > `PLBC_TOL_UNL
        |=> !o_lock) // [RULE11]
        else $error("lock not cleared outside unlock tolerance");

    a_irq_on_toggle: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        $changed(o_lock) && s.lie |-> o_irq && s.lock_flag) // [RULE12]
        else $error("lock change raised no interrupt");

    a_flag_held: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        s.lock_flag && !(wr_status && i_wr_data[`PLBC_ST_FLAG])
        |=> s.lock_flag) // [RULE18]
        else $error("lock flag lost without acknowledge");

    a_wait_keeps_run: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        i_wait_mode && o_loop_run && s.pwr && !i_stop_mode
        |=> o_loop_run) // [RULE3]
        else $error("loop stopped during wait");

    a_stop_suspend: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn) i_stop_mode |=> !o_loop_run [*2]) // [RULE4]
        else $error("loop running in stop");

    a_stab_hold: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        s.lp == LP_STAB && s.stab_cnt != '0 |=> !o_loop_run) // [RULE5]
        else $error("loop ran before stabilization ended");

    a_manual_exit: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        s.stop_q && !i_stop_mode && !s.auto_bw |=> !s.pwr) // [RULE5]
        else $error("manual loop restarted after stop");

    a_manual_track: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        !s.auto_bw && wr_ctrl
        |=> o_filter_track == $past(i_wr_data[`PLBC_CTRL_FTS])) // [RULE15]
        else $error("manual track write not applied");

    a_auto_acq_off: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        s.auto_bw && !s.loop_run |=> !o_filter_track) // [RULE10]
        else $error("auto mode tracking while loop off");

endmodule

// [inc/plbc_regs.svh]
`ifndef PLBC_REGS_SVH
`define PLBC_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PLBC_ADDR_W 8
`define PLBC_DATA_W 8
`define PLBC_OFS_CTRL 8'h00
`define PLBC_OFS_REFDIV 8'h01
`define PLBC_OFS_MULT 8'h02
`define PLBC_OFS_STATUS 8'h03

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PLBC_CTRL_AUTO 0
`define PLBC_CTRL_PWR 1
`define PLBC_CTRL_LIE 2
`define PLBC_CTRL_FTS 3
`define PLBC_ST_LOCK 0
`define PLBC_ST_FLAG 1
`define PLBC_ST_RUN 2
`define PLBC_ST_TRK 3

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define PLBC_DIV_W 3
`define PLBC_MUL_W 6
`define PLBC_ERR_W 6
`define PLBC_WIN_W 5
`define PLBC_WIN 16
`define PLBC_RST_AUTO 1'b1
`define PLBC_RST_REFDIV 3'h0
`define PLBC_RST_MULT 6'h00

// ----------------------------------------------------------------
// Lock window tolerances, in feedback pulses per window
// ----------------------------------------------------------------
`define PLBC_TOL_LOCK 6'h01
`define PLBC_TOL_UNL 6'h02
`define PLBC_TOL_TRK 6'h02
`define PLBC_TOL_UNT 6'h04

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PLBC_CLK_PERIOD_NS 25
`define PLBC_STAB_TIME_NS 20000
`define PLBC_STAB_CYC ((`PLBC_STAB_TIME_NS + `PLBC_CLK_PERIOD_NS - 1) / `PLBC_CLK_PERIOD_NS)
`define PLBC_STAB_W 10

`endif

// [inc/plbc_pkg.sv]
package plbc_pkg;
`include "plbc_regs.svh"

    // ------------------------------------------------------------
    // Loop phase
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LP_OFF = 3'h1,
        LP_STAB = 3'h2,
        LP_RUN = 3'h4
    } plbc_loop_t;

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    typedef struct packed {
        logic prev_xtal;
        logic prev_vco;
        logic [`PLBC_DIV_W-1:0] ref_div;
        logic [`PLBC_DIV_W-1:0] ref_cnt;
        logic [`PLBC_MUL_W-1:0] mult;
        logic [`PLBC_MUL_W-1:0] fb_cnt;
        logic auto_bw;
        logic pwr;
        logic lie;
        logic fts;
        logic lock;
        logic lock_flag;
        logic stop_q;
        plbc_loop_t lp;
        logic [`PLBC_STAB_W-1:0] stab_cnt;
        logic ref_pulse;
        logic fb_pulse;
        logic loop_run;
        logic irq;
        logic [`PLBC_DATA_W-1:0] rd_data;
    } plbc_state_t;

    // ------------------------------------------------------------
    // Lock detector state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`PLBC_WIN_W-1:0] win_cnt;
        logic [`PLBC_ERR_W-1:0] fb_cnt;
        logic valid;
        logic [`PLBC_ERR_W-1:0] err;
    } plbc_det_t;

endpackage

// [core/plbc_lock_det.sv]
`timescale 1ns/1ps
`include "plbc_regs.svh"

module plbc_lock_det
    import plbc_pkg::*;
#(
    parameter int WIN = `PLBC_WIN
)
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic i_ref_tick,
    input wire logic i_fb_tick,
    output logic o_valid,
    output logic [`PLBC_ERR_W-1:0] o_err
);

    localparam logic [`PLBC_ERR_W-1:0] WIN_E = `PLBC_ERR_W'(WIN);
    localparam logic [`PLBC_WIN_W-1:0] WIN_END = `PLBC_WIN_W'(WIN - 1);

    plbc_det_t s;
    plbc_det_t next_s;
    logic [`PLBC_ERR_W-1:0] fbc;

    // ------------------------------------------------------------
    // Count feedback pulses over a window of reference pulses
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.valid = 1'b0;
        fbc = s.fb_cnt;
        if (i_fb_tick && s.fb_cnt != {`PLBC_ERR_W{1'b1}})
        begin
            fbc = s.fb_cnt + `PLBC_ERR_W'(1);
        end
        next_s.fb_cnt = fbc;
        if (!i_enable)
        begin
            next_s.win_cnt = '0;
            next_s.fb_cnt = '0;
        end
        else if (i_ref_tick)
        begin
            if (s.win_cnt == WIN_END)
            begin
                // Frequency error of the window, either sign [RULE6]
                next_s.err = (fbc >= WIN_E) ? fbc - WIN_E : WIN_E - fbc;
                next_s.valid = 1'b1;
                next_s.win_cnt = '0;
                next_s.fb_cnt = '0;
            end
            else
            begin
                next_s.win_cnt = s.win_cnt + `PLBC_WIN_W'(1);
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign o_valid = s.valid;
    assign o_err = s.err;

    a_det_idle: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !i_enable |=> !o_valid) // [RULE6]
        else $error("window result while detector disabled");

endmodule

// [tb/plbc_clk_model.sv]
`timescale 1ns/1ps

module plbc_clk_model
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_loop_run,
    input wire logic [7:0] i_vco_half,
    output logic o_xtal_clk,
    output logic o_vco_clk
);
    logic [1:0] xcnt;
    logic [7:0] vcnt;

    // Crystal: four cycles high, four low; VCO halts when loop off
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            xcnt <= 2'h0;
            vcnt <= 8'h00;
            o_xtal_clk <= 1'b0;
            o_vco_clk <= 1'b0;
        end
        else
        begin
            xcnt <= xcnt + 2'h1;
            if (xcnt == 2'h3)
                o_xtal_clk <= ~o_xtal_clk;
            if (!i_loop_run)
            begin
                vcnt <= 8'h00;
                o_vco_clk <= 1'b0;
            end
            else if (vcnt + 8'h01 >= i_vco_half)
            begin
                vcnt <= 8'h00;
                o_vco_clk <= ~o_vco_clk;
            end
            else
                vcnt <= vcnt + 8'h01;
        end
    end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "plbc_regs.svh"

module tb_top;
    localparam int STAB = 4;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic wait_m = 1'b0;
    logic stop_m = 1'b0;
    logic [7:0] vh = 8'h04;
    logic xtal, vco, ref_p, fb_p, run, trk, lock, irq;
    logic [7:0] rdat;
    logic [7:0] m;
    logic [31:0] seed = 32'h45820544;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;

    plbc_ctrl #(.STAB_CYC(STAB)) i_plbc_ctrl (
        .i_core_clk(clk), .i_resetn(resetn), .i_addr(addr),
        .i_wr_data(wdat), .i_wr(wr_s), .i_rd(rd_s), .i_xtal_clk(xtal),
        .i_vco_output_clock(vco), .i_wait_mode(wait_m),
        .i_stop_mode(stop_m), .o_rd_data(rdat),
        .o_final_reference_clock(ref_p), .o_feedback_divided_clock(fb_p),
        .o_loop_run(run), .o_filter_track(trk), .o_lock(lock), .o_irq(irq));

    plbc_clk_model i_plbc_clk_model (
        .i_core_clk(clk), .i_resetn(resetn), .i_loop_run(run),
        .i_vco_half(vh), .o_xtal_clk(xtal), .o_vco_clk(vco));

    always #12.5 clk = ~clk;

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            err_total++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Bench helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction

    function automatic int fb_gap(input logic [7:0] mv, input logic [7:0] h);
        return 2 * int'(h) * (int'(mv) + 1);
    endfunction

    // 0 run, 1 lock, 2 track, 3 irq, 4 reference, 5 feedback
    function automatic logic sig(input int s);
        case (s)
            0: return run;
            1: return lock;
            2: return trk;
            3: return irq;
            4: return ref_p;
            default: return fb_p;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk(nm, {8'h00, e}, {8'h00, rdat});
    endtask

    task automatic wait_lvl(input int s, input logic v, input int lim);
        int k;
        k = 0;
        @(negedge clk);
        while (sig(s) !== v && k < lim)
        begin
            @(negedge clk);
            k++;
        end
    endtask

    task automatic gap(input int s, output int g);
        wait_lvl(s, 1'b1, 3000);
        g = 1;
        @(negedge clk);
        while (sig(s) !== 1'b1 && g < 3000)
        begin
            @(negedge clk);
            g++;
        end
    endtask

    task automatic tend(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("outs in reset", 16'h0000,
            {2'b00, rdat, ref_p, fb_p, run, trk, lock, irq});
        @(posedge clk);
        resetn <= 1'b1;
        rdc("ctrl rst", `PLBC_OFS_CTRL, 8'h01);
        rdc("refdiv rst", `PLBC_OFS_REFDIV, 8'h00);
        rdc("mult rst", `PLBC_OFS_MULT, 8'h00);
        rdc("status rst", `PLBC_OFS_STATUS, 8'h00);
        rdc("unmapped", 8'h04, 8'h00);
        rdc("unmapped", 8'hff, 8'h00);
        tend("reset");
        for (int d = 0; d < 8; d++)
        begin
            wr(`PLBC_OFS_REFDIV, 8'(d));
            gap(4, n);
            gap(4, n);
            chk("ref gap", 16'(8 * (d + 1)), 16'(n));
        end
        wr(`PLBC_OFS_REFDIV, 8'h00);
        tend("ref divider");
        wr(`PLBC_OFS_CTRL, 8'h03);
        wait_lvl(0, 1'b1, STAB + 10);
        chk("loop run", 16'h1, {15'h0, run});
        @(posedge clk);
        vh <= 8'h01;
        for (int i = 0; i < 8; i++)
        begin
            m = (i == 0) ? 8'h00 : (i == 1) ? 8'h3f : {2'b00, seed[5:0]};
            seed = lfsr(seed);
            wr(`PLBC_OFS_MULT, m);
            gap(5, n);
            gap(5, n);
            chk("fb gap", 16'(fb_gap(m, 8'h01)), 16'(n));
        end
        tend("multiplier");
        wr(`PLBC_OFS_MULT, 8'h00);
        wait_lvl(1, 1'b0, 600);
        wr(`PLBC_OFS_STATUS, 8'h02);
        @(posedge clk);
        vh <= 8'h04;
        wait_lvl(1, 1'b1, 1000);
        chk("lock", 16'h1, {15'h0, lock});
        wait_lvl(2, 1'b1, 300);
        chk("track", 16'h1, {15'h0, trk});
        rdc("status", `PLBC_OFS_STATUS, 8'h0f);
        chk("irq masked", 16'h0, {15'h0, irq});
        @(posedge clk);
        vh <= 8'h01;
        wait_lvl(1, 1'b0, 600);
        wait_lvl(2, 1'b0, 600);
        chk("unlock", 16'h0, {14'h0, lock, trk});
        wr(`PLBC_OFS_CTRL, 8'h0b);
        rdc("ctrl auto", `PLBC_OFS_CTRL, 8'h03);
        wr(`PLBC_OFS_CTRL, 8'h07);
        wait_lvl(3, 1'b1, 3);
        chk("irq pend", 16'h1, {15'h0, irq});
        wr(`PLBC_OFS_STATUS, 8'h02);
        wait_lvl(3, 1'b0, 3);
        repeat (300) @(negedge clk);
        chk("irq ack", 16'h0, {15'h0, irq});
        @(posedge clk);
        vh <= 8'h04;
        wait_lvl(3, 1'b1, 1000);
        chk("irq relock", 16'h3, {14'h0, irq, lock});
        wr(`PLBC_OFS_STATUS, 8'h02);
        tend("auto lock");
        @(posedge clk);
        wait_m <= 1'b1;
        repeat (400) @(negedge clk);
        chk("wait mode", 16'h7, {13'h0, run, lock, trk});
        @(posedge clk);
        wait_m <= 1'b0;
        stop_m <= 1'b1;
        @(negedge clk);
        @(negedge clk);
        chk("stop run", 16'h0, {15'h0, run});
        wait_lvl(1, 1'b0, 2);
        chk("stop lock", 16'h0, {14'h0, lock, trk});
        repeat (50) @(posedge clk);
        stop_m <= 1'b0;
        wait_lvl(0, 1'b1, STAB + 4);
        chk("stop exit", 16'h1, {15'h0, run});
        wait_lvl(1, 1'b1, 1000);
        chk("relock", 16'h1, {15'h0, lock});
        tend("wait and stop");
        wr(`PLBC_OFS_STATUS, 8'h02);
        // Leave auto first; track bit is only writable once manual
        wr(`PLBC_OFS_CTRL, 8'h02);
        wr(`PLBC_OFS_CTRL, 8'h02);
        wait_lvl(2, 1'b0, 4);
        repeat (400) @(negedge clk);
        chk("manual acq", 16'h2, {14'h0, lock, trk});
        wr(`PLBC_OFS_CTRL, 8'h0a);
        wait_lvl(2, 1'b1, 4);
        chk("manual trk", 16'h1, {15'h0, trk});
        rdc("status man", `PLBC_OFS_STATUS, 8'h0d);
        wr(`PLBC_OFS_CTRL, 8'h0e);
        @(posedge clk);
        vh <= 8'h01;
        wait_lvl(3, 1'b1, 1000);
        chk("manual irq", 16'h5, {13'h0, irq, lock, trk});
        wr(`PLBC_OFS_STATUS, 8'h02);
        wr(`PLBC_OFS_CTRL, 8'h02);
        @(posedge clk);
        stop_m <= 1'b1;
        repeat (20) @(posedge clk);
        stop_m <= 1'b0;
        repeat (40) @(negedge clk);
        chk("manual stop", 16'h0, {15'h0, run});
        rdc("ctrl manual", `PLBC_OFS_CTRL, 8'h00);
        tend("manual");
        end_sim();
    end
endmodule
